// ---- common/mas_pkg.sv ----
/*
  Shared constants and carriers for the microcode address sequencer.
  Assumes the control store word outside the sequencer carries the jump field
  in its low bits; all other outside bits are opaque to the sequencer.
*/
package mas_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 11;
  localparam int DISP_W      = 5;
  localparam int STACK_DEPTH = 4;
  localparam int DISP_WORDS  = 1280;
  localparam int EXT_W       = 24;
  localparam int IOB_W       = 36;
  localparam int FUNC_W      = 6;
  localparam int UPPER_W     = 7;
  localparam int LOWER_W     = 4;

  // ----------------------------------------------------------------
  // diagnostic function codes on the internal I/O bus
  // ----------------------------------------------------------------
  localparam logic [FUNC_W-1:0] FN_LOAD_DIAG_HI = 6'h29;
  localparam logic [FUNC_W-1:0] FN_LOAD_DIAG_LO = 6'h2A;
  localparam logic [FUNC_W-1:0] FN_WRITE_DISP   = 6'h2B;
  localparam logic [FUNC_W-1:0] FN_WRITE_EXT    = 6'h2C;

  // ----------------------------------------------------------------
  // dispatch field decode and forced addresses
  // ----------------------------------------------------------------
  localparam logic [DISP_W-1:0] DISP_DIAG     = 5'h00;
  localparam logic [DISP_W-1:0] DISP_AREAD    = 5'h02;
  localparam logic [DISP_W-1:0] DISP_EXT_BASE = 5'h18;
  localparam logic [ADDR_W-1:0] FORCE_MASK    = 11'h3FF;
  localparam logic [ADDR_W-1:0] DISP_LIMIT    = 11'h500;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST  = 11'h000;
  localparam logic [DISP_W-1:0] DISP_RST  = 5'h00;
  localparam logic [EXT_W-1:0]  EXT_RST   = 24'h000000;
  localparam logic [IOB_W-1:0]  IOB_RST   = 36'h000000000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [EXT_W-1:0]  ext;
    logic [ADDR_W-1:0] jump;
  } mas_cs_word_s;

  typedef struct packed {
    logic [EXT_W-1:0]  ext;
    logic [DISP_W-1:0] disp;
    logic [ADDR_W-1:0] jump;
  } mas_mir_s;

  typedef struct packed {
    logic              strobe;
    logic [FUNC_W-1:0] func;
    logic [IOB_W-1:0]  data;
  } mas_diag_s;

endpackage : mas_pkg

// ---- src/mas_shift_stack_bit.sv ----
/*
  One bit column of the return-address shift stack.
  Assumes push and pop are from logic on the same clock.
*/
`timescale 1ns/100ps
module mas_shift_stack_bit #(
  parameter int DEPTH = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic push_i,
  input  wire logic pop_i,
  input  wire logic bit_i,
  output logic      top_o
);

  logic [DEPTH-1:0] stage;

  // ----------------------------------------------------------------
  // shift column: index 0 is the top entry
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage <= '0;
    end else if (push_i) begin
      // deepest entry falls off when full
      stage <= {stage[DEPTH-2:0], bit_i};
    end else if (pop_i) begin
      stage <= {1'b0, stage[DEPTH-1:1]};
    end
  end

  assign top_o = stage[0];

endmodule : mas_shift_stack_bit

// ---- src/mas_sequencer.sv ----
/*
  Microcode address sequencer: next-address mixers, current-location
  register, return-address shift stack, local dispatch-field store,
  microinstruction register and diagnostic address register.
  Assumes the decode logic, the page-fault source and the diagnostic bus
  controller all run on SYS_CLK_I; the outside control store returns the
  word at NEXT_CONTROL_ADDRESS_O in time for the next edge.
*/
`timescale 1ns/100ps
module mas_sequencer (
  input  wire logic                          SYS_CLK_I,
  input  wire logic                          RST_I,
  input  wire logic                          PUSH_CALL_I,
  input  wire logic                          POP_RETURN_I,
  input  wire logic                          PAGE_FAULT_I,
  input  wire logic                          COND_ADR10_I,
  input  wire logic [mas_pkg::ADDR_W-1:0]    AREAD_I,
  input  wire logic [mas_pkg::LOWER_W-1:0]   DISP_MOD_I,
  input  wire mas_pkg::mas_cs_word_s         CS_WORD_I,
  input  wire mas_pkg::mas_diag_s            DIAG_I,
  output logic [mas_pkg::ADDR_W-1:0]         NEXT_CONTROL_ADDRESS_O,
  output mas_pkg::mas_mir_s                  MIR_O,
  output logic [mas_pkg::ADDR_W-1:0]         CURRENT_LOCATION_O,
  output logic [mas_pkg::ADDR_W-1:0]         DIAG_ADDR_O,
  output logic                               CS_WRITE_O,
  output logic [mas_pkg::ADDR_W-1:0]         CS_WRITE_ADDR_O,
  output logic [mas_pkg::IOB_W-1:0]          CS_WRITE_DATA_O
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mas_pkg::mas_mir_s                mir;
  logic [mas_pkg::ADDR_W-1:0]       current_location_reg;
  logic [mas_pkg::ADDR_W-1:0]       diag_addr;
  logic [mas_pkg::ADDR_W-1:0]       stack_top;
  logic [mas_pkg::ADDR_W-1:0]       next_control_address;
  logic [mas_pkg::DISP_W-1:0]       disp_store [mas_pkg::DISP_WORDS];
  logic [mas_pkg::DISP_W-1:0]       disp_read;
  logic                             push_call_control;
  logic                             pop_return_control;
  logic                             diag_load_hi;
  logic                             diag_load_lo;
  logic                             diag_write_disp;
  logic                             diag_write_ext;
  logic                             disp_in_range;
  logic                             wr_in_range;
  logic                             cs_write;
  logic [mas_pkg::ADDR_W-1:0]       cs_write_addr;
  logic [mas_pkg::IOB_W-1:0]        cs_write_data;

  // ----------------------------------------------------------------
  // stack controls
  // ----------------------------------------------------------------
  // the decode logic looks at the loaded microinstruction, so its call
  // request lands on the edge after the load; a page fault forces a call
  // so the interrupted location is saved for the handler's return
  assign push_call_control  = PUSH_CALL_I | PAGE_FAULT_I;
  // a push in the same cycle wins over a pop inside the stack columns
  assign pop_return_control = POP_RETURN_I;

  // ----------------------------------------------------------------
  // shift stack, one column per address bit
  // ----------------------------------------------------------------
  for (genvar b = 0; b < mas_pkg::ADDR_W; b++) begin : g_shift_stack
    mas_shift_stack_bit #(
      .DEPTH (mas_pkg::STACK_DEPTH)
    ) u_col (
      .clk_i  (SYS_CLK_I),
      .rst_i  (RST_I),
      .push_i (push_call_control),
      .pop_i  (pop_return_control),
      .bit_i  (current_location_reg[b]),
      .top_o  (stack_top[b])
    );
  end

  // ----------------------------------------------------------------
  // next-address mixers and output gates
  // ----------------------------------------------------------------
  // a zero dispatch field selects the diagnostic address in place of the jump field;
  // every other source is ORed in, so none can clear a one already present
  always_comb begin
    next_control_address = mas_pkg::ADDR_RST;
    if (mir.disp == mas_pkg::DISP_DIAG) begin
      // zero dispatch after reset steers both groups to diagnostics
      next_control_address = diag_addr;
    end else begin
      next_control_address = mir.jump;
    end
    if (mir.disp == mas_pkg::DISP_AREAD) begin
      next_control_address = next_control_address | AREAD_I;
    end
    if (mir.disp >= mas_pkg::DISP_EXT_BASE) begin
      next_control_address[mas_pkg::LOWER_W-1:0] =
        next_control_address[mas_pkg::LOWER_W-1:0] | DISP_MOD_I;
    end
    if (pop_return_control) begin
      // the jump field or diagnostic address, with any dispatch merges, acts as the return modifier
      next_control_address = next_control_address | stack_top;
    end
    next_control_address[0] = next_control_address[0] | COND_ADR10_I;
    if (PAGE_FAULT_I) begin
      // top bit kept, so the handler is entered at either half
      next_control_address = next_control_address | mas_pkg::FORCE_MASK;
    end
  end

  assign NEXT_CONTROL_ADDRESS_O = next_control_address;

  // ----------------------------------------------------------------
  // current-location register
  // ----------------------------------------------------------------
  // on a pop this also catches the modifier that was being presented
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      current_location_reg <= mas_pkg::ADDR_RST;
    end else begin
      current_location_reg <= next_control_address;
    end
  end

  assign CURRENT_LOCATION_O = current_location_reg;

  // ----------------------------------------------------------------
  // local dispatch-field store
  // ----------------------------------------------------------------
  assign disp_in_range = next_control_address < mas_pkg::DISP_LIMIT;
  assign wr_in_range   = diag_addr < mas_pkg::DISP_LIMIT;

  always_ff @(posedge SYS_CLK_I) begin
    if (diag_write_disp && wr_in_range) begin
      disp_store[diag_addr] <= DIAG_I.data[mas_pkg::DISP_W-1:0];
    end
  end

  // addresses above the local store read as a zero dispatch field
  always_comb begin
    disp_read = mas_pkg::DISP_RST;
    if (disp_in_range) begin
      disp_read = disp_store[next_control_address];
    end
  end

  // ----------------------------------------------------------------
  // microinstruction register
  // ----------------------------------------------------------------
  // the outside word and the local dispatch bits load on the same edge
  // as the address capture, so decode starts on the new word at once
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      mir.jump <= mas_pkg::ADDR_RST;
      mir.disp <= mas_pkg::DISP_RST;
      mir.ext  <= mas_pkg::EXT_RST;
    end else begin
      mir.jump <= CS_WORD_I.jump;
      mir.disp <= disp_read;
      mir.ext  <= CS_WORD_I.ext;
    end
  end

  assign MIR_O = mir;

  // ----------------------------------------------------------------
  // diagnostic function decode
  // ----------------------------------------------------------------
  assign diag_load_hi    = DIAG_I.strobe && (DIAG_I.func == mas_pkg::FN_LOAD_DIAG_HI);
  assign diag_load_lo    = DIAG_I.strobe && (DIAG_I.func == mas_pkg::FN_LOAD_DIAG_LO);
  assign diag_write_disp = DIAG_I.strobe && (DIAG_I.func == mas_pkg::FN_WRITE_DISP);
  assign diag_write_ext  = DIAG_I.strobe && (DIAG_I.func == mas_pkg::FN_WRITE_EXT);

  // ----------------------------------------------------------------
  // diagnostic address register
  // ----------------------------------------------------------------
  // the two halves load separately so a bus controller with narrow
  // data paths can still reach every word of the store
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      diag_addr <= mas_pkg::ADDR_RST;
    end else begin
      if (diag_load_hi) begin
        diag_addr[mas_pkg::ADDR_W-1:mas_pkg::LOWER_W] <=
          DIAG_I.data[mas_pkg::UPPER_W-1:0];
      end
      if (diag_load_lo) begin
        diag_addr[mas_pkg::LOWER_W-1:0] <=
          DIAG_I.data[mas_pkg::LOWER_W-1:0];
      end
    end
  end

  assign DIAG_ADDR_O = diag_addr;

  // ----------------------------------------------------------------
  // write strobe to the store portion outside the sequencer
  // ----------------------------------------------------------------
  // registered so address, data and strobe reach the store together;
  // costs one cycle of latency on every outside-store write
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      cs_write <= 1'b0;
    end else begin
      cs_write <= diag_write_ext;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      cs_write_addr <= mas_pkg::ADDR_RST;
      cs_write_data <= mas_pkg::IOB_RST;
    end else if (diag_write_ext) begin
      cs_write_addr <= diag_addr;
      cs_write_data <= DIAG_I.data;
    end
  end

  assign CS_WRITE_O      = cs_write;
  assign CS_WRITE_ADDR_O = cs_write_addr;
  assign CS_WRITE_DATA_O = cs_write_data;

endmodule : mas_sequencer

// ---- verification/mas_sequencer_checker.sv ----
/* Port checker for the microcode address sequencer.
   Assumes one clock and a synchronous active-high reset; bound to every instance. */
`timescale 1ns/100ps
module mas_sequencer_checker (
  input wire logic                  SYS_CLK_I,
  input wire logic                  RST_I,
  input wire logic                  PUSH_CALL_I,
  input wire logic                  POP_RETURN_I,
  input wire logic                  PAGE_FAULT_I,
  input wire logic                  COND_ADR10_I,
  input wire logic [10:0]           AREAD_I,
  input wire logic [3:0]            DISP_MOD_I,
  input wire mas_pkg::mas_cs_word_s CS_WORD_I,
  input wire mas_pkg::mas_diag_s    DIAG_I,
  input wire logic [10:0]           NEXT_CONTROL_ADDRESS_O,
  input wire mas_pkg::mas_mir_s     MIR_O,
  input wire logic [10:0]           CURRENT_LOCATION_O,
  input wire logic [10:0]           DIAG_ADDR_O,
  input wire logic                  CS_WRITE_O,
  input wire logic [10:0]           CS_WRITE_ADDR_O,
  input wire logic [35:0]           CS_WRITE_DATA_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // ----------------------------------------
  // shadow of the latest push, dropped by a pop
  // ----------------------------------------
  logic [10:0] top_shadow;
  logic        top_live;
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      top_live <= 1'b0;
    end else if (PUSH_CALL_I || PAGE_FAULT_I) begin
      top_live <= 1'b1;
    end else if (POP_RETURN_I) begin
      top_live <= 1'b0;
    end
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (PUSH_CALL_I || PAGE_FAULT_I) begin
      top_shadow <= CURRENT_LOCATION_O;
    end
  end
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_addr_load;
    DIAG_I.strobe && DIAG_I.func == mas_pkg::FN_LOAD_DIAG_HI ##1 !DIAG_I.strobe
      ##1 DIAG_I.strobe && DIAG_I.func == mas_pkg::FN_LOAD_DIAG_LO;
  endsequence
  sequence s_ext_req;
    DIAG_I.strobe && DIAG_I.func == mas_pkg::FN_WRITE_EXT;
  endsequence
  property p_loc;
    !$past(RST_I) |-> CURRENT_LOCATION_O === $past(NEXT_CONTROL_ADDRESS_O);
  endproperty
  property p_mir;
    !$past(RST_I) |-> MIR_O.jump === $past(CS_WORD_I.jump) && MIR_O.ext === $past(CS_WORD_I.ext);
  endproperty
  property p_reset;
    $past(RST_I) |-> MIR_O === '0 && CURRENT_LOCATION_O === '0 && DIAG_ADDR_O === '0;
  endproperty
  property p_diag_sel;
    MIR_O.disp === mas_pkg::DISP_DIAG |-> (NEXT_CONTROL_ADDRESS_O & DIAG_ADDR_O) === DIAG_ADDR_O;
  endproperty
  property p_aread;
    MIR_O.disp === mas_pkg::DISP_AREAD |-> (NEXT_CONTROL_ADDRESS_O & AREAD_I) === AREAD_I;
  endproperty
  property p_fault;
    PAGE_FAULT_I |-> NEXT_CONTROL_ADDRESS_O[9:0] === 10'h3FF;
  endproperty
  property p_cond;
    COND_ADR10_I |-> NEXT_CONTROL_ADDRESS_O[0] === 1'b1;
  endproperty
  property p_return;
    POP_RETURN_I && !PUSH_CALL_I && !PAGE_FAULT_I && top_live
      |-> (NEXT_CONTROL_ADDRESS_O & top_shadow) === top_shadow;
  endproperty
  property p_addr_load;
    s_addr_load |=> DIAG_ADDR_O === {$past(DIAG_I.data[6:0], 3), $past(DIAG_I.data[3:0])};
  endproperty
  property p_ext_write;
    s_ext_req |=> CS_WRITE_O && CS_WRITE_ADDR_O === $past(DIAG_ADDR_O)
      && CS_WRITE_DATA_O === $past(DIAG_I.data);
  endproperty
  a_loc: assert property (p_loc) else $error("location differs from last address");
  a_mir: assert property (p_mir) else $error("fetched word not loaded");
  a_reset: assert property (p_reset) else $error("reset state not zero");
  a_diag_sel: assert property (p_diag_sel) else $error("diagnostic source lost");
  a_aread: assert property (p_aread) else $error("opcode dispatch not merged");
  a_fault: assert property (p_fault) else $error("fault address not forced");
  a_cond: assert property (p_cond) else $error("skip bit not set");
  a_return: assert property (p_return) else $error("stack top not merged");
  a_addr_load: assert property (p_addr_load) else $error("diag address wrong");
  a_ext_write: assert property (p_ext_write) else $error("store write wrong");
endmodule : mas_sequencer_checker

bind mas_sequencer mas_sequencer_checker u_check (
  .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .PUSH_CALL_I(PUSH_CALL_I),
  .POP_RETURN_I(POP_RETURN_I), .PAGE_FAULT_I(PAGE_FAULT_I), .COND_ADR10_I(COND_ADR10_I),
  .AREAD_I(AREAD_I), .DISP_MOD_I(DISP_MOD_I), .CS_WORD_I(CS_WORD_I), .DIAG_I(DIAG_I),
  .NEXT_CONTROL_ADDRESS_O(NEXT_CONTROL_ADDRESS_O), .MIR_O(MIR_O),
  .CURRENT_LOCATION_O(CURRENT_LOCATION_O), .DIAG_ADDR_O(DIAG_ADDR_O),
  .CS_WRITE_O(CS_WRITE_O), .CS_WRITE_ADDR_O(CS_WRITE_ADDR_O),
  .CS_WRITE_DATA_O(CS_WRITE_DATA_O));

// ---- verification/mas_cs_model.sv ----
/* Outside control store model: word read at the presented address.
   Assumes writes arrive as the sequencer's registered write strobe. */
`timescale 1ns/100ps
module mas_cs_model (
  input  wire logic        clk_i,
  input  wire logic [10:0] addr_i,
  input  wire logic        we_i,
  input  wire logic [10:0] waddr_i,
  input  wire logic [35:0] wdata_i,
  output mas_pkg::mas_cs_word_s word_o
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  mas_pkg::mas_cs_word_s mem [2048];
  // zero jump keeps unwritten words from steering the address
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = '{ext: 24'h5A5A5A, jump: 11'h000};
    end
  end
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= mas_pkg::mas_cs_word_s'(wdata_i[34:0]);
    end
  end
  assign word_o = mem[addr_i];
endmodule : mas_cs_model

// ---- verification/mas_sequencer_bench.sv ----
/* Self-checking bench for mas_sequencer with an outside store model.
   Assumes the dispatch store is filled by diagnostic writes before use. */
`timescale 1ns/100ps
module mas_sequencer_bench;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  push = 1'b0;
  logic                  pop = 1'b0;
  logic                  fault = 1'b0;
  logic                  cond = 1'b0;
  logic [10:0]           aread = 11'h2C5;
  logic [3:0]            disp_mod = 4'h6;
  mas_pkg::mas_diag_s    diag = '0;
  mas_pkg::mas_cs_word_s cs_word;
  mas_pkg::mas_mir_s     mir;
  logic [10:0]           next_addr;
  logic [10:0]           loc;
  logic [10:0]           diag_addr;
  logic                  cs_we;
  logic [10:0]           cs_waddr;
  logic [35:0]           cs_wdata;
  int                    miscompares = 0;
  int                    samples_checked = 0;
  int                    cycles = 0;

  always #50 clk = ~clk;

  mas_sequencer DUT (
    .SYS_CLK_I(clk), .RST_I(rst), .PUSH_CALL_I(push), .POP_RETURN_I(pop),
    .PAGE_FAULT_I(fault), .COND_ADR10_I(cond), .AREAD_I(aread), .DISP_MOD_I(disp_mod),
    .CS_WORD_I(cs_word), .DIAG_I(diag), .NEXT_CONTROL_ADDRESS_O(next_addr), .MIR_O(mir),
    .CURRENT_LOCATION_O(loc), .DIAG_ADDR_O(diag_addr), .CS_WRITE_O(cs_we),
    .CS_WRITE_ADDR_O(cs_waddr), .CS_WRITE_DATA_O(cs_wdata));
  mas_cs_model u_store (.clk_i(clk), .addr_i(next_addr), .we_i(cs_we), .waddr_i(cs_waddr),
    .wdata_i(cs_wdata), .word_o(cs_word));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic test_done();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // fill takes about 9000 cycles, so this ceiling only trips on a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic diag_fn(input logic [5:0] f, input logic [35:0] d);
    @(posedge clk);
    diag <= '{strobe: 1'b1, func: f, data: d};
    @(posedge clk);
    diag.strobe <= 1'b0;
  endtask : diag_fn
  task automatic set_diag(input logic [10:0] a);
    diag_fn(mas_pkg::FN_LOAD_DIAG_HI, 36'(a[10:4]));
    diag_fn(mas_pkg::FN_LOAD_DIAG_LO, 36'(a[3:0]));
    @(posedge clk);
  endtask : set_diag
  task automatic ret_pop(input logic [10:0] exp);
    @(posedge clk);
    pop <= 1'b1;
    @(negedge clk);
    chk("return address", 36'(exp), 36'(next_addr));
    @(posedge clk);
    pop <= 1'b0;
    @(negedge clk);
    chk("current location", 36'(exp), 36'(loc));
  endtask : ret_pop
  task automatic wait_disp(input logic [4:0] v);
    for (int i = 0; i < 4 && mir.disp !== v; i++) begin
      @(negedge clk);
    end
    chk("dispatch field", 36'(v), 36'(mir.disp));
  endtask : wait_disp
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_fill_store();
    logic [4:0] v;
    for (int a = 0; a < 1280; a++) begin
      v = (a == 11'h4FF) ? 5'h1F : ((a == 11'h123) ? 5'h02 : 5'h00);
      set_diag(11'(a));
      diag_fn(mas_pkg::FN_WRITE_DISP, 36'(v));
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("mir ext", 36'h0, 36'(mir.ext));
    chk("mir disp and jump", 36'h0, 36'({mir.disp, mir.jump}));
    chk("current location", 36'h0, 36'(loc));
    chk("next address", 36'h0, 36'(next_addr));
  endtask : t_fill_store
  task automatic t_ext_write();
    set_diag(11'h600);
    chk("diagnostic address", 36'h600, 36'(diag_addr));
    diag_fn(mas_pkg::FN_WRITE_EXT, 36'h012345800);
    @(negedge clk);
    chk("write strobe", 36'h1, 36'(cs_we));
    chk("write address", 36'h600, 36'(cs_waddr));
    chk("write data", 36'h012345800, cs_wdata);
    @(negedge clk);
    chk("write strobe", 36'h0, 36'(cs_we));
    @(negedge clk);
    chk("loaded word", 36'h02468B, 36'(mir.ext));
  endtask : t_ext_write
  task automatic t_call_return();
    set_diag(11'h0A0);
    @(posedge clk);
    push <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    set_diag(11'h140);
    @(posedge clk);
    push <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    set_diag(11'h001);
    ret_pop(11'h141);
    ret_pop(11'h0A1);
    ret_pop(11'h001);
  endtask : t_call_return
  // five pushes into a four-deep stack: the first one must fall off
  task automatic t_deep_stack();
    for (int k = 1; k <= 5; k++) begin
      set_diag(11'(k << 4));
      @(posedge clk);
      push <= 1'b1;
      @(posedge clk);
      push <= 1'b0;
    end
    set_diag(11'h000);
    for (int k = 5; k >= 2; k--) begin
      ret_pop(11'(k << 4));
    end
    ret_pop(11'h000);
  endtask : t_deep_stack
  task automatic t_force();
    set_diag(11'h400);
    @(posedge clk);
    fault <= 1'b1;
    @(negedge clk);
    chk("forced address", 36'h7FF, 36'(next_addr));
    @(posedge clk);
    fault <= 1'b0;
    cond <= 1'b1;
    @(negedge clk);
    chk("skip address", 36'h401, 36'(next_addr));
    @(posedge clk);
    cond <= 1'b0;
  endtask : t_force
  task automatic t_dispatch();
    set_diag(11'h4FF);
    wait_disp(5'h1F);
    chk("modified address", 36'h006, 36'(next_addr));
    set_diag(11'h123);
    wait_disp(5'h02);
    chk("opcode dispatch", 36'h2C5, 36'(next_addr));
  endtask : t_dispatch

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_fill_store();
    t_ext_write();
    t_call_return();
    t_deep_stack();
    t_force();
    t_dispatch();
    test_done();
  end
endmodule : mas_sequencer_bench
